// ---- core/tws_pkg.sv ----
package tws_pkg;
  // Status codes, full byte with prescaler bits masked to zero
  localparam logic [7:0] ST_START     = 8'h08;
  localparam logic [7:0] ST_RSTART    = 8'h10;
  localparam logic [7:0] ST_SLA_ACK   = 8'h60;
  localparam logic [7:0] ST_GC_ACK    = 8'h70;
  localparam logic [7:0] ST_DATA_ACK  = 8'h80;
  localparam logic [7:0] ST_DATA_NACK = 8'h88;
  localparam logic [7:0] ST_GCD_ACK   = 8'h90;
  localparam logic [7:0] ST_GCD_NACK  = 8'h98;
  localparam logic [7:0] ST_STOP      = 8'hA0;
  localparam logic [7:0] ST_NOINFO    = 8'hF8;
  localparam logic [7:0] ST_BUSERR    = 8'h00;
  localparam int SC_MSB = 7;
  localparam int SC_LSB = 3;
  localparam int PS_MSB = 1;
  // Register word indices, byte address is four times the index
  localparam int ADR_W = 3;
  localparam logic [2:0] ADR_DATA   = 3'h0;
  localparam logic [2:0] ADR_STATUS = 3'h1;
  localparam logic [2:0] ADR_OWN    = 3'h2;
  localparam logic [2:0] ADR_CTRL   = 3'h3;
  localparam logic [2:0] ADR_IRQST  = 3'h4;
  localparam logic [2:0] ADR_MASK   = 3'h5;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int REG_W = 8;
  // Control register bits
  localparam int CTRL_FLAG  = 7;
  localparam int CTRL_ACK   = 6;
  localparam int CTRL_START = 5;
  localparam int CTRL_STOP  = 4;
  localparam int CTRL_EN    = 2;
  localparam int GCE_BIT    = 0;
  localparam logic [7:0] GC_ADDR = 8'h00;
  // Interrupt status and mask bits
  localparam int IRQ_W    = 3;
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_ERR  = 1;
  localparam int IRQ_STOP = 2;
  localparam logic [7:0] DATA_RST = 8'h01;
  localparam logic [7:0] OWN_RST  = 8'h02;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Bus condition timing
  localparam int CLK_NS  = 5;
  localparam int HOLD_NS = 2500;
  localparam int HOLD_CYC_DEF = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 16;
  localparam logic [2:0] LINE_IDLE = 3'h7;
endpackage

// ---- core/tws_if.sv ----
`timescale 1ns/10ps
interface tws_if;
  logic                      wrStb;
  logic                      rdStb;
  logic [tws_pkg::ADR_W-1:0] addr;
  logic [tws_pkg::REG_W-1:0] wdata;
  logic [tws_pkg::REG_W-1:0] rdata;
  logic                      sclIn;
  logic                      sdaIn;
  logic                      sclRise;
  logic                      sclFall;
  logic                      startDet;
  logic                      stopDet;
  modport wbs (output wrStb, rdStb, addr, wdata, input rdata);
  modport lin (output sclIn, sdaIn, sclRise, sclFall, startDet, stopDet);
  modport core (input wrStb, rdStb, addr, wdata, sclIn, sdaIn, sclRise, sclFall,
                input startDet, stopDet, output rdata);
endinterface

// ---- core/tws_line_sync.sv ----
`timescale 1ns/10ps
module tws_line_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic sclPin,
  input  wire logic sdaPin,
  tws_if.lin        ln
);
  import tws_pkg::*;
  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
  } tws_sync_t;
  tws_sync_t r;
  tws_sync_t n;

  // Stage 0 feeds stage 1 only; edges come from stages 1 and 2
  always_comb begin
    n = r;
    n.scl = {r.scl[1:0], sclPin};
    n.sda = {r.sda[1:0], sdaPin};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{scl: LINE_IDLE, sda: LINE_IDLE};
    end else begin
      r <= n;
    end
  end

  assign ln.sclIn    = r.scl[1];
  assign ln.sdaIn    = r.sda[1];
  assign ln.sclRise  = r.scl[1] && !r.scl[2];
  assign ln.sclFall  = !r.scl[1] && r.scl[2];
  assign ln.startDet = r.sda[2] && !r.sda[1] && r.scl[1] && r.scl[2];
  assign ln.stopDet  = !r.sda[2] && r.sda[1] && r.scl[1] && r.scl[2];
endmodule

// ---- core/tws_wb_port.sv ----
`timescale 1ns/10ps
module tws_wb_port (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      cyc,
  input  wire logic                      stb,
  input  wire logic                      we,
  input  wire logic [tws_pkg::WB_AW-1:0] adr,
  input  wire logic [3:0]                sel,
  input  wire logic [tws_pkg::WB_DW-1:0] datIn,
  output logic      [tws_pkg::WB_DW-1:0] datOut,
  output logic                           ack,
  tws_if.wbs                             rb
);
  import tws_pkg::*;
  typedef struct packed {
    logic             ackR;
    logic [REG_W-1:0] datR;
  } tws_wbst_t;
  tws_wbst_t r;
  tws_wbst_t n;
  logic      req;
  logic      hit;

  assign req = cyc && stb;
  assign hit = (adr[WB_AW-1:ADR_W+2] == '0);

  // Read data captured as ack rises; unmapped reads give zero
  always_comb begin
    n = r;
    n.ackR = req && !r.ackR;
    if (req && !r.ackR) begin
      n.datR = (hit && !we) ? rb.rdata : '0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Write lands on the edge where the master sees ack
  assign rb.wrStb = req && we && r.ackR && hit && sel[0];
  assign rb.rdStb = req && !we && !r.ackR && hit;
  assign rb.addr  = adr[ADR_W+1:2];
  assign rb.wdata = datIn[REG_W-1:0];
  assign ack      = r.ackR;
  assign datOut   = {{(WB_DW-REG_W){1'b0}}, r.datR};
endmodule

// ---- core/tws_slave_top.sv ----
`timescale 1ns/10ps
// Overview of operation
// - A general-call data byte answered with NOT ACK reports 0x98, raises the flag, keeps the byte.
// - Leaving an end state goes not addressed; address match needs acknowledge enable set.
// - A begin request left set after an end state sends START once the bus is free.
// - STOP or repeated START while addressed reports 0xA0 and raises the flag.
// - With the flag clear the status field reads the no-information code 0xF8.
// - START or STOP inside a byte or an acknowledge bit is a bus error, code 0x00, flag set.
// - Clearing the flag with end request set after a bus error idles and clears only that bit.
// - Bus error recovery releases both lines and sends no STOP.
// - After a repeated START the master keeps holding the clock low to own the bus.
// - Status byte holds the code in bits 7 to 3 and the prescaler in bits 1 to 0.
// - Own address bit 0 enables general call, bits 7 to 1 hold the slave address.
module tws_slave_top #(
  parameter int HOLD_CYC = tws_pkg::HOLD_CYC_DEF
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [tws_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [tws_pkg::WB_DW-1:0] wb_dat_i,
  output logic      [tws_pkg::WB_DW-1:0] wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      sclI,
  output logic                           sclO,
  output logic                           sclOe,
  input  wire logic                      sdaI,
  output logic                           sdaO,
  output logic                           sdaOe,
  output logic                           irq
);
  import tws_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_DATA, S_DATA_ACK, S_WAIT} tws_sst_t;
  typedef enum logic [2:0] {M_IDLE, M_START, M_HOLD, M_RS_SDA, M_RS_SCL, M_STP_SDA,
                            M_STP_SCL} tws_mst_t;
  typedef struct packed {
    tws_sst_t         sst;
    tws_sst_t         waitNext;
    tws_mst_t         mst;
    logic [3:0]       bitCnt;
    logic [7:0]       shift;
    logic [7:0]       data;
    logic [4:0]       code;
    logic             flag;
    logic             ackEn;
    logic             startReq;
    logic             stopReq;
    logic             enable;
    logic             gcMatch;
    logic             lastAck;
    logic             rep;
    logic             busy;
    logic             sdaOe;
    logic             sclOe;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       ownAddr;
    logic [PS_MSB:0]  presc;
    logic [IRQ_W-1:0] irqSt;
    logic [IRQ_W-1:0] irqMsk;
  } tws_core_t;

  localparam tws_core_t CORE_RST = '{sst: S_IDLE, waitNext: S_IDLE, mst: M_IDLE,
                                     data: DATA_RST, ownAddr: OWN_RST,
                                     code: ST_NOINFO[SC_MSB:SC_LSB], default: '0};

  tws_if     bus ();
  tws_core_t r;
  tws_core_t n;
  logic      slaveRun;
  logic      holdDone;
  logic      evErr;
  logic      evStop;
  logic      ownHitW;
  logic      gcHitW;
  logic [7:0] statusByte;

  tws_wb_port u_wb (
    .clk    (clk),
    .resetn (resetn),
    .cyc    (wb_cyc_i),
    .stb    (wb_stb_i),
    .we     (wb_we_i),
    .adr    (wb_adr_i),
    .sel    (wb_sel_i),
    .datIn  (wb_dat_i),
    .datOut (wb_dat_o),
    .ack    (wb_ack_o),
    .rb     (bus.wbs)
  );

  tws_line_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .sclPin (sclI),
    .sdaPin (sdaI),
    .ln     (bus.lin)
  );

  function automatic logic [4:0] sc(input logic [7:0] st);
    return st[SC_MSB:SC_LSB];
  endfunction

  function automatic logic [7:0] dataCode(input logic gc, input logic ackd);
    if (gc) begin
      return ackd ? ST_GCD_ACK : ST_GCD_NACK;
    end
    return ackd ? ST_DATA_ACK : ST_DATA_NACK;
  endfunction

  // Raise the flag and park the slave until software answers
  function automatic tws_core_t park(input tws_core_t s, input logic [7:0] st,
                                     input tws_sst_t nx);
    tws_core_t t;
    t = s;
    t.flag = 1'b1;
    t.code = sc(st);
    t.sst = S_WAIT;
    t.waitNext = nx;
    return t;
  endfunction

  assign ownHitW = (r.shift[7:1] == r.ownAddr[7:1]) && !r.shift[0];
  assign gcHitW = (r.shift == GC_ADDR) && r.ownAddr[GCE_BIT];
  assign holdDone = (r.cnt == CNT_W'(HOLD_CYC - 1));
  assign statusByte = {(r.flag ? r.code : sc(ST_NOINFO)), 1'b0, r.presc};

  always_comb begin
    n = r;
    evErr = 1'b0;
    evStop = 1'b0;
    slaveRun = r.enable && (r.mst == M_IDLE);
    if (bus.startDet) begin
      n.busy = 1'b1;
    end
    if (bus.stopDet) begin
      n.busy = 1'b0;
    end
    // Software first, so a hardware event in the same cycle wins
    if (bus.wrStb) begin
      unique case (bus.addr)
        ADR_DATA: if (r.flag) n.data = bus.wdata;
        ADR_STATUS: n.presc = bus.wdata[PS_MSB:0];
        ADR_OWN: n.ownAddr = bus.wdata;
        ADR_CTRL: begin
          n.ackEn = bus.wdata[CTRL_ACK];
          n.startReq = bus.wdata[CTRL_START];
          n.stopReq = bus.wdata[CTRL_STOP];
          n.enable = bus.wdata[CTRL_EN];
          if (bus.wdata[CTRL_FLAG]) begin
            n.flag = 1'b0;
          end
          if (bus.wdata[CTRL_FLAG] && bus.wdata[CTRL_STOP] && r.flag &&
              r.code == sc(ST_BUSERR)) begin
            n.stopReq = 1'b0;
            n.sst = S_IDLE;
            n.sdaOe = 1'b0;
            n.sclOe = 1'b0;
          end
        end
        ADR_MASK: n.irqMsk = bus.wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (bus.rdStb && bus.addr == ADR_IRQST) begin
      n.irqSt = '0;
    end

    if (!r.enable) begin
      n.sst = S_IDLE;
      n.mst = M_IDLE;
      n.sdaOe = 1'b0;
      n.sclOe = 1'b0;
    end else if (slaveRun) begin
      unique case (r.sst)
        S_IDLE: begin
          if (bus.startDet) begin
            n.sst = S_ADDR;
            n.bitCnt = '0;
          end
        end
        S_ADDR, S_DATA: begin
          if (bus.sclRise) begin
            n.shift = {r.shift[6:0], bus.sdaIn};
            n.bitCnt = r.bitCnt + 4'h1;
          end
          // The condition's own clock rise is counted, so one sampled bit is still a boundary
          if ((bus.startDet || bus.stopDet) && r.bitCnt > 4'h1) begin
            n = park(n, ST_BUSERR, S_IDLE);
            n.sdaOe = 1'b0;
            n.sclOe = 1'b0;
            evErr = 1'b1;
          end else if (bus.startDet || bus.stopDet) begin
            n.bitCnt = '0;
            if (r.sst == S_DATA) begin
              n = park(n, ST_STOP, bus.startDet ? S_ADDR : S_IDLE);
              evStop = 1'b1;
            end else begin
              n.sst = bus.startDet ? S_ADDR : S_IDLE;
            end
          end else if (bus.sclFall && r.bitCnt == BYTE_BITS) begin
            if (r.sst == S_DATA) begin
              n.lastAck = r.ackEn;
              n.sdaOe = r.ackEn;
              n.sst = S_DATA_ACK;
            end else if (r.ackEn && (ownHitW || gcHitW)) begin
              n.gcMatch = gcHitW;
              n.sdaOe = 1'b1;
              n.sst = S_ADDR_ACK;
            end else begin
              n.sst = S_IDLE;
            end
          end
        end
        S_ADDR_ACK, S_DATA_ACK: begin
          if (bus.startDet || bus.stopDet) begin
            n = park(n, ST_BUSERR, S_IDLE);
            n.sdaOe = 1'b0;
            n.sclOe = 1'b0;
            evErr = 1'b1;
          end else if (bus.sclFall) begin
            n.sdaOe = 1'b0;
            if (r.sst == S_ADDR_ACK) begin
              n = park(n, r.gcMatch ? ST_GC_ACK : ST_SLA_ACK, S_DATA);
            end else begin
              n.data = r.shift;
              n = park(n, dataCode(r.gcMatch, r.lastAck), r.lastAck ? S_DATA : S_IDLE);
            end
          end
        end
        S_WAIT: begin
          if (r.flag) begin
            // Stretch only once the master has pulled the clock low itself
            if (r.code != sc(ST_BUSERR) && !bus.sclIn) begin
              n.sclOe = 1'b1;
            end
          end else begin
            n.sclOe = 1'b0;
            n.sst = r.waitNext;
            n.bitCnt = '0;
          end
        end
        default: n.sst = S_IDLE;
      endcase
    end

    if (r.enable) begin
      n.cnt = (r.mst == M_IDLE || r.mst == M_HOLD || holdDone) ? '0 : r.cnt + 16'h0001;
      unique case (r.mst)
        M_IDLE: begin
          if (r.startReq && !r.busy && !r.flag && r.sst == S_IDLE && !bus.startDet) begin
            n.mst = M_START;
            n.sdaOe = 1'b1;
            n.rep = 1'b0;
          end
        end
        M_START: begin
          if (holdDone) begin
            n.sclOe = 1'b1;
            n.flag = 1'b1;
            n.code = sc(r.rep ? ST_RSTART : ST_START);
            n.mst = M_HOLD;
          end
        end
        M_HOLD: begin
          n.sclOe = 1'b1;
          if (!r.flag && r.stopReq) begin
            n.sdaOe = 1'b1;
            n.mst = M_STP_SDA;
          end else if (!r.flag && r.startReq) begin
            n.sdaOe = 1'b0;
            n.mst = M_RS_SDA;
          end
        end
        M_RS_SDA: if (holdDone) begin
          n.sclOe = 1'b0;
          n.mst = M_RS_SCL;
        end
        M_RS_SCL: if (holdDone) begin
          n.sdaOe = 1'b1;
          n.rep = 1'b1;
          n.mst = M_START;
        end
        M_STP_SDA: if (holdDone) begin
          n.sclOe = 1'b0;
          n.mst = M_STP_SCL;
        end
        M_STP_SCL: if (holdDone) begin
          n.sdaOe = 1'b0;
          n.stopReq = 1'b0;
          n.mst = M_IDLE;
        end
        default: n.mst = M_IDLE;
      endcase
    end
    n.irqSt[IRQ_FLAG] = n.irqSt[IRQ_FLAG] | (n.flag & !r.flag);
    n.irqSt[IRQ_ERR] = n.irqSt[IRQ_ERR] | evErr;
    n.irqSt[IRQ_STOP] = n.irqSt[IRQ_STOP] | evStop;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= CORE_RST;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    unique case (bus.addr)
      ADR_DATA: bus.rdata = r.data;
      ADR_STATUS: bus.rdata = statusByte;
      ADR_OWN: bus.rdata = r.ownAddr;
      ADR_CTRL: bus.rdata = {r.flag, r.ackEn, r.startReq, r.stopReq, 1'b0, r.enable, 2'h0};
      ADR_IRQST: bus.rdata = {{(REG_W-IRQ_W){1'b0}}, r.irqSt};
      ADR_MASK: bus.rdata = {{(REG_W-IRQ_W){1'b0}}, r.irqMsk};
      default: bus.rdata = '0;
    endcase
  end

  assign sclO = 1'b0;
  assign sdaO = 1'b0;
  assign sclOe = r.sclOe;
  assign sdaOe = r.sdaOe;
  assign irq = |(r.irqSt & r.irqMsk);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  gc_nack_byte_a: assert property (
    (slaveRun && r.sst == S_DATA_ACK && bus.sclFall && r.gcMatch && !r.lastAck &&
     !bus.startDet && !bus.stopDet && !bus.wrStb)
    |=> (r.flag && r.code == sc(ST_GCD_NACK) && r.data == $past(r.shift)))
    else $error("general call nack byte not reported");
  end_state_idle_a: assert property (
    (slaveRun && r.sst == S_WAIT && !r.flag && r.waitNext == S_IDLE && !bus.wrStb)
    |=> r.sst == S_IDLE)
    else $error("end state did not return to not addressed");
  start_when_free_a: assert property (
    (r.enable && r.mst == M_IDLE && r.startReq && !r.busy && !r.flag &&
     r.sst == S_IDLE && !bus.startDet && !bus.wrStb)
    |=> (r.mst == M_START && r.sdaOe) ##1 r.sdaOe)
    else $error("start not sent on free bus");
  stop_addressed_a: assert property (
    (slaveRun && r.sst == S_DATA && r.bitCnt <= 4'h1 && bus.stopDet && !bus.wrStb)
    |=> (r.flag && r.code == sc(ST_STOP) && r.waitNext == S_IDLE))
    else $error("stop while addressed not reported");
  no_info_code_a: assert property (
    !r.flag |-> statusByte[SC_MSB:SC_LSB] == sc(ST_NOINFO))
    else $error("status not no-information with flag clear");
  bus_error_set_a: assert property (
    (slaveRun && (r.sst == S_DATA || r.sst == S_ADDR) && r.bitCnt > 4'h1 &&
     (bus.startDet || bus.stopDet) && !bus.wrStb)
    |=> (r.flag && r.code == sc(ST_BUSERR) && r.irqSt[IRQ_ERR]))
    else $error("bus error not flagged");
  error_recover_a: assert property (
    (bus.wrStb && bus.addr == ADR_CTRL && bus.wdata[CTRL_FLAG] && bus.wdata[CTRL_STOP] &&
     bus.wdata[CTRL_EN] && r.flag && r.code == sc(ST_BUSERR))
    |=> (!r.stopReq && r.ackEn == $past(bus.wdata[CTRL_ACK]) && r.sst != S_WAIT)
        ##1 (r.mst == M_IDLE || r.mst == M_START))
    else $error("bus error recovery wrong");
  error_release_a: assert property (
    (r.flag && r.code == sc(ST_BUSERR) && r.mst == M_IDLE) |-> (!r.sdaOe && !r.sclOe))
    else $error("lines held during bus error");
  master_hold_a: assert property (
    (r.mst == M_HOLD && r.enable) |-> (r.sclOe && $past(r.sdaOe)))
    else $error("master released bus while owning it");
  status_layout_a: assert property (
    (statusByte[2] == 1'b0) && (statusByte[PS_MSB:0] == r.presc))
    else $error("status byte layout wrong");
  gc_disabled_a: assert property (
    (slaveRun && r.sst == S_ADDR && bus.sclFall && r.bitCnt == BYTE_BITS &&
     r.shift == GC_ADDR && !r.ownAddr[GCE_BIT] && !bus.startDet && !bus.stopDet && !bus.wrStb)
    |=> (r.sst == S_IDLE && !r.sdaOe))
    else $error("general call taken while disabled");

  gc_nack_seen_c: cover property (r.flag && r.code == sc(ST_GCD_NACK));
  stop_seen_c: cover property (r.flag && r.code == sc(ST_STOP));
  bus_error_seen_c: cover property (r.flag && r.code == sc(ST_BUSERR));
  rep_start_seen_c: cover property (r.mst == M_HOLD && r.rep);
endmodule

// ---- dv/tws_bus_master.sv ----
`timescale 1ns/10ps
module tws_bus_master (
  input  wire logic linkClk,
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output logic      sclDrv,
  output logic      sdaDrv
);
  logic ackSeen;
  int   stalls;
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
    ackSeen = 1'b1;
    stalls = 0;
  end
  // Bounded, so a slave that never lets go cannot hang the run
  task automatic sclUp();
    int n;
    n = 0;
    @(posedge linkClk) sclDrv <= 1'b1;
    while (sclLine !== 1'b1 && n < 2000) begin
      @(posedge linkClk);
      n++;
    end
    if (sclLine !== 1'b1) stalls++;
  endtask
  task automatic busStart();
    @(posedge linkClk) sdaDrv <= 1'b1;
    sclUp();
    @(posedge linkClk) sdaDrv <= 1'b0;
    @(posedge linkClk) sclDrv <= 1'b0;
  endtask
  task automatic busStop();
    @(posedge linkClk) sdaDrv <= 1'b0;
    sclUp();
    @(posedge linkClk) sdaDrv <= 1'b1;
  endtask
  // Short counts leave the frame mid-byte; eight adds the acknowledge clock
  task automatic sendBits(input logic [7:0] val, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      @(posedge linkClk) sdaDrv <= val[i];
      sclUp();
      @(posedge linkClk) sclDrv <= 1'b0;
    end
    if (nb == 8) begin
      @(posedge linkClk) sdaDrv <= 1'b1;
      sclUp();
      ackSeen = sdaLine;
      @(posedge linkClk) sclDrv <= 1'b0;
    end
  endtask
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
  import tws_pkg::*;
  logic        clk, linkClk, resetn, wbCyc, wbStb, wbWe;
  logic [7:0]  wbAdr;
  logic [31:0] wbDat, wbDatO;
  logic        wbAck, sclO, sclOe, sdaO, sdaOe, irq, mScl, mSda;
  int          mismatches, samplesChecked;
  wire logic   sclLine = (sclOe ? sclO : 1'b1) & mScl;
  wire logic   sdaLine = (sdaOe ? sdaO : 1'b1) & mSda;
  tws_slave_top #(.HOLD_CYC(4)) dut_u (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .sclI(sclLine), .sclO(sclO), .sclOe(sclOe), .sdaI(sdaLine),
    .sdaO(sdaO), .sdaOe(sdaOe), .irq(irq));
  tws_bus_master mst_u (.linkClk(linkClk), .sclLine(sclLine), .sdaLine(sdaLine),
    .sclDrv(mScl), .sdaDrv(mSda));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #7 forever #24 linkClk = ~linkClk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang();
    mismatches++;
    $display("wrong value at %0t: timeout", $time);
    close_out();
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 50) hang();
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, {3'h0, i, 2'h0}, d, q);
  endtask
  task automatic rd(input logic [2:0] i, input logic [7:0] e);
    logic [31:0] q;
    xfer(1'b0, {3'h0, i, 2'h0}, 8'h00, q);
    `CHK(q, {24'h0, e})
  endtask
  // Polls a control bit; the byte already ended, so the bound is generous
  task automatic waitCtrl(input int b, input logic v);
    logic [31:0] q;
    int n;
    q = {32{~v}};
    for (n = 0; n < 300 && q[b] !== v; n++) xfer(1'b0, {3'h0, ADR_CTRL, 2'h0}, 8'h00, q);
    if (q[b] !== v) hang();
  endtask
  task automatic gcByte(input logic [7:0] d, input logic ak, input logic [7:0] st);
    mst_u.sendBits(d, 8);
    `CHK(mst_u.ackSeen, ak)
    waitCtrl(CTRL_FLAG, 1'b1);
    rd(ADR_STATUS, st);
  endtask
  initial begin
    logic [31:0] q;
    {wbCyc, wbStb, wbWe, wbAdr, wbDat, mismatches, samplesChecked} = '0;
    resetn = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(ADR_DATA, DATA_RST);
    rd(ADR_STATUS, ST_NOINFO);
    rd(ADR_OWN, OWN_RST);
    rd(ADR_CTRL, 8'h00);
    rd(ADR_IRQST, 8'h00);
    rd(ADR_MASK, 8'h00);
    wr(ADR_STATUS, 8'h03);
    rd(ADR_STATUS, ST_NOINFO | 8'h03);
    wr(ADR_STATUS, 8'h00);
    wr(3'h6, 8'h5A);
    rd(3'h6, 8'h00);
    xfer(1'b0, 8'h20, 8'h00, q);
    `CHK(q, 32'h0)
    $display("test resets done");
    wr(ADR_OWN, 8'h03);
    wr(ADR_CTRL, 8'h44);
    mst_u.busStart();
    gcByte(8'h00, 1'b0, ST_GC_ACK);
    `CHK(irq, 1'b0)
    wr(ADR_MASK, 8'h07);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    rd(ADR_IRQST, 8'h01);
    `CHK(irq, 1'b0)
    wr(ADR_CTRL, 8'h84);
    gcByte(8'hA5, 1'b1, ST_GCD_NACK);
    rd(ADR_DATA, 8'hA5);
    wr(ADR_CTRL, 8'h84);
    mst_u.busStop();
    rd(ADR_STATUS, ST_NOINFO);
    mst_u.busStart();
    mst_u.sendBits(8'h00, 8);
    `CHK(mst_u.ackSeen, 1'b1)
    mst_u.busStop();
    $display("test nack done");
    wr(ADR_CTRL, 8'hC4);
    mst_u.busStart();
    gcByte(8'h00, 1'b0, ST_GC_ACK);
    wr(ADR_CTRL, 8'hC4);
    gcByte(8'h3C, 1'b0, ST_GCD_ACK);
    rd(ADR_DATA, 8'h3C);
    rd(ADR_IRQST, 8'h01);
    wr(ADR_CTRL, 8'hC4);
    mst_u.busStop();
    waitCtrl(CTRL_FLAG, 1'b1);
    rd(ADR_STATUS, ST_STOP);
    rd(ADR_IRQST, 8'h05);
    wr(ADR_CTRL, 8'hE4);
    waitCtrl(CTRL_FLAG, 1'b1);
    rd(ADR_STATUS, ST_START);
    `CHK(sclOe, 1'b1)
    wr(ADR_CTRL, 8'hA4);
    waitCtrl(CTRL_FLAG, 1'b1);
    rd(ADR_STATUS, ST_RSTART);
    `CHK(sclOe, 1'b1)
    wr(ADR_CTRL, 8'h94);
    waitCtrl(CTRL_STOP, 1'b0);
    rd(ADR_STATUS, ST_NOINFO);
    `CHK({sclOe, sdaOe}, 2'b00)
    $display("test stop and start done");
    rd(ADR_IRQST, 8'h01);
    wr(ADR_CTRL, 8'h44);
    mst_u.busStart();
    mst_u.sendBits(8'h55, 4);
    mst_u.busStop();
    waitCtrl(CTRL_FLAG, 1'b1);
    rd(ADR_STATUS, ST_BUSERR);
    rd(ADR_IRQST, 8'h03);
    wr(ADR_CTRL, 8'hD4);
    waitCtrl(CTRL_STOP, 1'b0);
    rd(ADR_CTRL, 8'h44);
    `CHK({sclOe, sdaOe, sclLine, sdaLine}, 4'b0011)
    rd(ADR_STATUS, ST_NOINFO);
    $display("test bus error done");
    `CHK(mst_u.stalls, 0)
    close_out();
  end
endmodule
